/* aasp_host_model.sv */
// host side model: clocks the link as master, captures the data
// assumes resolved clock, sync and data pin levels at its inputs
`timescale 1ns/1ns
module aasp_host_model (
	input  wire logic   host_run_in,
	input  wire logic   bclk_w_in,
	input  wire logic   fs_w_in,
	input  wire logic   data_w_in,
	output logic        host_bclk_out,
	output logic        host_fs_out,
	output logic [63:0] after_rise_out,
	output logic [63:0] after_fall_out,
	output logic [15:0] frame_len_out
);
	logic [5:0] cnt_ff;
	logic [9:0] ir_ff;
	logic [9:0] if_ff;
	logic       fs_prev_ff;

	initial begin
		host_bclk_out = 1'b1;
		host_fs_out = 1'b0;
		cnt_ff = 6'h3F;
		ir_ff = 10'h3FF;
		if_ff = 10'h3FF;
		fs_prev_ff = 1'b0;
		frame_len_out = 16'h0000;
	end

	// host clock and sync, 64 bits a frame, sync high first half
	always #200 if (host_run_in) begin
		host_bclk_out = !host_bclk_out;
		if (!host_bclk_out) begin
			cnt_ff = cnt_ff + 6'h01;
			host_fs_out = !cnt_ff[5];
		end
	end

	// capture at each rise, counted from the last sync rise and fall
	always @(posedge bclk_w_in) begin
		if (fs_w_in && !fs_prev_ff) begin
			frame_len_out = {6'h00, ir_ff} + 16'h0001;
			ir_ff = 10'h000;
		end else if (ir_ff != 10'h3FF) ir_ff = ir_ff + 10'h001;
		if (!fs_w_in && fs_prev_ff) if_ff = 10'h000;
		else if (if_ff != 10'h3FF) if_ff = if_ff + 10'h001;
		if (ir_ff < 10'h040) after_rise_out[ir_ff[5:0]] = data_w_in;
		if (if_ff < 10'h040) after_fall_out[if_ff[5:0]] = data_w_in;
		fs_prev_ff = fs_w_in;
	end
endmodule : aasp_host_model

/* aasp_pkg.sv */
// constants and types of the audio serial output port
// assumes a 20 MHz core clock and an Avalon-MM register bus
package aasp_pkg;

	// ----------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------
	localparam logic [7:0] IDX_FMT   = 8'h07;
	localparam logic [7:0] IDX_COMP  = 8'h25;
	localparam logic [7:0] IDX_SLOTL = 8'h5B;
	localparam logic [7:0] IDX_SLOTC = 8'h5C;
	localparam logic [7:0] IDX_SLOTR = 8'h5D;
	localparam logic [7:0] IDX_CLK   = 8'h60;
	localparam logic [7:0] IDX_STAT  = 8'h61;

	// values after reset
	localparam logic [8:0] RST_FMT   = 9'h020;
	localparam logic [8:0] RST_COMP  = 9'h000;
	localparam logic [8:0] RST_SLOTL = 9'h000;
	localparam logic [8:0] RST_SLOTC = 9'h020;
	localparam logic [8:0] RST_SLOTR = 9'h020;
	localparam logic [8:0] RST_CLK   = 9'h000;

	// field positions
	localparam int FMT_LSB  = 0;
	localparam int WORD_LENGTH_LSB = 2;
	localparam int FSP_BIT  = 4;
	localparam int MS_BIT   = 6;
	localparam int COMP_LSB = 1;
	localparam int TSEN_BIT = 8;
	localparam int TRI_BIT  = 7;
	localparam int P8_BIT   = 5;
	localparam int OES_BIT  = 2;
	localparam int SLH_BIT  = 1;
	localparam int SRH_BIT  = 0;

	// encodings
	localparam logic [1:0] FMT_RJ  = 2'h0;
	localparam logic [1:0] FMT_LJ  = 2'h1;
	localparam logic [1:0] FMT_I2S = 2'h2;
	localparam logic [1:0] FMT_PCM = 2'h3;
	localparam logic [1:0] COMP_MU = 2'h2;
	localparam logic [1:0] COMP_A  = 2'h3;
	localparam logic [7:0] ALAW_XOR = 8'h55;

	// timing of the generated bit clock
	localparam int CLK_PERIOD_NS  = 50;
	localparam int BCLK_PERIOD_NS = 400;
	localparam int BCLK_HALF_CYC  = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		AASP_PH_IDLE, AASP_PH_LEFT, AASP_PH_RIGHT, AASP_PH_FRAME
	} aasp_phase_t;

	typedef struct packed {
		logic [1:0] fmt;
		logic [1:0] word_length;
		logic       sync_polarity_variant;
		logic       master_sel;
		logic [1:0] comp;
		logic       slot_mode_en;
		logic       tri_early;
		logic       byte_word_force;
		logic       out_enable_select;
		logic [9:0] left_slot_start;
		logic [9:0] right_slot_start;
		logic [1:0] frame_sel;
	} aasp_cfg_t;

endpackage : aasp_pkg

/* aasp_serial_port.sv */
// serial audio output port with register file and companding
// assumes bit clock and frame sync pins outside the core clock domain
`timescale 1ns/1ns

module aasp_serial_port #(
	parameter int BCLK_HALF = aasp_pkg::BCLK_HALF_CYC
) (
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	input  wire logic [9:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        bclk_in,
	output logic             bclk_out,
	output logic             bclk_oe_n_out,
	input  wire logic        frame_sync_in,
	output logic             frame_sync_out,
	output logic             frame_sync_oe_n_out,
	output logic             serial_data_out,
	output logic             serial_data_oe_n_out,
	input  wire logic [23:0] left_sample_in,
	input  wire logic [23:0] right_sample_in,
	output logic             sample_take_out
);

	// ----------------------------------------------------------
	// functions
	// ----------------------------------------------------------
	// mu-law code of a 13-bit sample
	function automatic logic [7:0] mu_enc(input logic [12:0] s);
		logic [12:0] m;
		logic [2:0]  e;
		m = s[12] ? 13'(~s + 13'h1) : s;
		m = 13'(m + 13'h21);
		e = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (m[i + 5]) begin
				e = 3'(i);
			end
		end
		return ~{s[12], e, 4'(m >> (4'(e) + 4'h1))};
	endfunction : mu_enc

	// a-law code of a 12-bit sample
	function automatic logic [7:0] a_enc(input logic [11:0] s);
		logic [11:0] m;
		logic [2:0]  e;
		m = s[11] ? 12'(~s + 12'h1) : s;
		m = (m[11] ? 12'h7FF : m) << 1;
		e = 3'h0;
		for (int i = 5; i < 12; i++) begin
			if (m[i]) begin
				e = 3'(i - 4);
			end
		end
		m = (e == 3'h0) ? (m >> 1) : (m >> e);
		return {~s[11], e, m[3:0]} ^ aasp_pkg::ALAW_XOR;
	endfunction : a_enc

	// sample to msb-aligned word, companded when asked
	function automatic logic [31:0] mk_word(input logic [23:0] s,
			input logic [1:0] c);
		case (c)
			aasp_pkg::COMP_MU: return {mu_enc(s[23:11]), 24'h00_0000};
			aasp_pkg::COMP_A:  return {a_enc(s[23:12]), 24'h00_0000};
			default:           return {s, 8'h00};
		endcase
	endfunction : mk_word

	// true when rise k falls in a word starting at rise st
	function automatic logic in_win(input logic [9:0] k,
			input logic [9:0] st, input logic [5:0] w);
		return (k >= st) && ((k - st) < 10'(w));
	endfunction : in_win

	// ----------------------------------------------------------
	// registers
	// ----------------------------------------------------------
	logic [8:0]  fmt_ff, comp_ff, slotl_ff, slotc_ff, slotr_ff, clk_ff;
	logic        bclk_s1_ff, bclk_s2_ff, fs_s1_ff, fs_s2_ff;
	logic        bk_prev_ff, fs_prev_ff, pend_ff, lsb_ff;
	logic        bclk_gen_ff, fs_gen_ff;
	logic [7:0]  div_ff;
	logic [7:0]  fcnt_ff;
	logic [9:0]  kcnt_ff;
	logic [31:0] lword_ff, rword_ff;
	aasp_pkg::aasp_phase_t ph_ff;
	aasp_pkg::aasp_cfg_t   cfg;

	logic        req, bk, fsl, b_fall, b_rise, fs_rise, fs_edge, start;
	logic [9:0]  k, half, off;
	logic [5:0]  w;
	logic [8:0]  nfr;
	logic        valid, bit_val, is_lsb;
	aasp_pkg::aasp_phase_t ph_new;

	// configuration fields gathered into one carrier
	assign cfg.fmt = fmt_ff[aasp_pkg::FMT_LSB +: 2];
	assign cfg.word_length = fmt_ff[aasp_pkg::WORD_LENGTH_LSB +: 2];
	assign cfg.sync_polarity_variant = fmt_ff[aasp_pkg::FSP_BIT];
	assign cfg.master_sel = fmt_ff[aasp_pkg::MS_BIT];
	assign cfg.comp = comp_ff[aasp_pkg::COMP_LSB +: 2];
	assign cfg.slot_mode_en = slotc_ff[aasp_pkg::TSEN_BIT];
	assign cfg.tri_early = slotc_ff[aasp_pkg::TRI_BIT];
	assign cfg.byte_word_force = slotc_ff[aasp_pkg::P8_BIT];
	assign cfg.out_enable_select = slotc_ff[aasp_pkg::OES_BIT];
	assign cfg.left_slot_start = {slotc_ff[aasp_pkg::SLH_BIT], slotl_ff};
	assign cfg.right_slot_start = {slotc_ff[aasp_pkg::SRH_BIT], slotr_ff};
	assign cfg.frame_sel = clk_ff[1:0];

	// ----------------------------------------------------------
	// avalon slave: one wait cycle, then answer
	// ----------------------------------------------------------
	assign req = avs_read_in || avs_write_in;

	// waitrequest low for one cycle per request
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= !(req && avs_waitrequest_out);
		end
	end

	// read data loaded in the wait cycle
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && avs_waitrequest_out) begin
			case (avs_address_in[9:2])
				aasp_pkg::IDX_FMT:   avs_readdata_out <= 32'(fmt_ff);
				aasp_pkg::IDX_COMP:  avs_readdata_out <= 32'(comp_ff);
				aasp_pkg::IDX_SLOTL: avs_readdata_out <= 32'(slotl_ff);
				aasp_pkg::IDX_SLOTC: avs_readdata_out <= 32'(slotc_ff);
				aasp_pkg::IDX_SLOTR: avs_readdata_out <= 32'(slotr_ff);
				aasp_pkg::IDX_CLK:   avs_readdata_out <= 32'(clk_ff);
				aasp_pkg::IDX_STAT:
					avs_readdata_out <= 32'({~serial_data_oe_n_out,
						fsl, bk, ph_ff});
				default:             avs_readdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// writes take effect at the edge that ends the waitrequest-low cycle
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			fmt_ff   <= aasp_pkg::RST_FMT;
			comp_ff  <= aasp_pkg::RST_COMP;
			slotl_ff <= aasp_pkg::RST_SLOTL;
			slotc_ff <= aasp_pkg::RST_SLOTC;
			slotr_ff <= aasp_pkg::RST_SLOTR;
			clk_ff   <= aasp_pkg::RST_CLK;
		end else if (avs_write_in && !avs_waitrequest_out) begin
			case (avs_address_in[9:2])
				aasp_pkg::IDX_FMT:   fmt_ff   <= avs_writedata_in[8:0];
				aasp_pkg::IDX_COMP:  comp_ff  <= avs_writedata_in[8:0];
				aasp_pkg::IDX_SLOTL: slotl_ff <= avs_writedata_in[8:0];
				aasp_pkg::IDX_SLOTC: slotc_ff <= avs_writedata_in[8:0];
				aasp_pkg::IDX_SLOTR: slotr_ff <= avs_writedata_in[8:0];
				aasp_pkg::IDX_CLK:   clk_ff   <= avs_writedata_in[8:0];
				default:             fmt_ff   <= fmt_ff;
			endcase
		end
	end

	// ----------------------------------------------------------
	// master clock and sync generation
	// ----------------------------------------------------------
	// frame length in bit clocks
	always_comb begin
		case (cfg.frame_sel)
			2'h1:    nfr = 9'd128;
			2'h2:    nfr = 9'd64;
			2'h3:    nfr = 9'd32;
			default: nfr = 9'd256;
		endcase
	end

	// divider; sync changes together with the bit clock fall
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			div_ff      <= 8'h00;
			bclk_gen_ff <= 1'b1;
			fs_gen_ff   <= 1'b0;
			fcnt_ff     <= 8'h00;
		end else if (div_ff >= 8'(BCLK_HALF - 1)) begin
			div_ff      <= 8'h00;
			bclk_gen_ff <= !bclk_gen_ff;
			if (bclk_gen_ff) begin
				fcnt_ff <= (9'(fcnt_ff) >= nfr - 9'h1) ? 8'h00 :
					8'(fcnt_ff + 8'h1);
				if (cfg.fmt == aasp_pkg::FMT_PCM) begin
					fs_gen_ff <= (9'(fcnt_ff) >= nfr - 9'h1);
				end else if (cfg.fmt == aasp_pkg::FMT_I2S) begin
					fs_gen_ff <= (9'(fcnt_ff) + 9'h1 >= nfr >> 1) &&
						(9'(fcnt_ff) + 9'h1 < nfr);
				end else begin
					fs_gen_ff <= (9'(fcnt_ff) + 9'h1 >= nfr) ||
						(9'(fcnt_ff) + 9'h1 < nfr >> 1);
				end
			end
		end else begin
			div_ff <= 8'(div_ff + 8'h1);
		end
	end

	// pin drivers for clock and sync
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			bclk_out            <= 1'b1;
			frame_sync_out      <= 1'b0;
			bclk_oe_n_out       <= 1'b1;
			frame_sync_oe_n_out <= 1'b1;
		end else begin
			bclk_out            <= bclk_gen_ff;
			frame_sync_out      <= fs_gen_ff;
			bclk_oe_n_out       <= !cfg.master_sel;
			frame_sync_oe_n_out <= !cfg.master_sel;
		end
	end

	// ----------------------------------------------------------
	// link sampling and edge detection
	// ----------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			bclk_s1_ff <= 1'b1; // bit clock idles high, no false edge
			bclk_s2_ff <= 1'b1;
			fs_s1_ff   <= 1'b0;
			fs_s2_ff   <= 1'b0;
			bk_prev_ff <= 1'b1;
			fs_prev_ff <= 1'b0;
		end else begin
			bclk_s1_ff <= bclk_in;
			bclk_s2_ff <= bclk_s1_ff;
			fs_s1_ff   <= frame_sync_in;
			fs_s2_ff   <= fs_s1_ff;
			bk_prev_ff <= bk;
			fs_prev_ff <= fsl;
		end
	end

	assign bk      = cfg.master_sel ? bclk_out : bclk_s2_ff;
	assign fsl     = cfg.master_sel ? frame_sync_out : fs_s2_ff;
	assign b_fall  = bk_prev_ff && !bk;
	assign b_rise  = !bk_prev_ff && bk;
	assign fs_rise = !fs_prev_ff && fsl;
	assign fs_edge = (cfg.fmt == aasp_pkg::FMT_PCM) ? fs_rise :
		(fs_prev_ff != fsl);
	assign start   = b_fall && (fs_edge || pend_ff);

	// ----------------------------------------------------------
	// bit selection for the next rising edge
	// ----------------------------------------------------------
	always_comb begin
		case (cfg.word_length)
			2'h0:    w = 6'd16;
			2'h1:    w = 6'd20;
			2'h2:    w = 6'd24;
			default: w = 6'd32;
		endcase
		if (cfg.byte_word_force) begin
			w = 6'd8;
		end
	end

	assign half = 10'(nfr >> 1);
	assign k = start ? 10'h000 : kcnt_ff;

	// phase chosen at a sync edge
	always_comb begin
		if (!start) begin
			ph_new = ph_ff;
		end else if (cfg.fmt == aasp_pkg::FMT_PCM) begin
			ph_new = aasp_pkg::AASP_PH_FRAME;
		end else if (cfg.fmt == aasp_pkg::FMT_I2S) begin
			ph_new = fsl ? aasp_pkg::AASP_PH_RIGHT :
				aasp_pkg::AASP_PH_LEFT;
		end else begin
			ph_new = fsl ? aasp_pkg::AASP_PH_LEFT :
				aasp_pkg::AASP_PH_RIGHT;
		end
	end

	// which word bit is due and whether one is due at all
	always_comb begin
		logic [31:0] wd;
		logic [9:0]  b;
		logic [31:0] lw;
		logic [31:0] rw;
		// a new frame sends its fresh samples from the very first bit
		lw    = (start && ph_new != aasp_pkg::AASP_PH_RIGHT) ?
			mk_word(left_sample_in, cfg.comp) : lword_ff;
		rw    = (start && ph_new != aasp_pkg::AASP_PH_RIGHT) ?
			mk_word(right_sample_in, cfg.comp) : rword_ff;
		wd    = lw;
		b     = 10'h000;
		valid = 1'b0;
		off   = 10'h000;
		case (cfg.fmt)
			aasp_pkg::FMT_I2S: off = 10'h001;
			aasp_pkg::FMT_RJ:
				off = (half > 10'(w)) ? 10'(half - 10'(w)) : 10'h000;
			default:           off = 10'h000;
		endcase
		case (ph_new)
			aasp_pkg::AASP_PH_LEFT, aasp_pkg::AASP_PH_RIGHT: begin
				wd    = (ph_new == aasp_pkg::AASP_PH_LEFT) ? lw : rw;
				valid = in_win(k, off, w);
				b     = 10'(k - off);
			end
			aasp_pkg::AASP_PH_FRAME: begin
				if (cfg.slot_mode_en) begin
					if (in_win(k, cfg.left_slot_start, w)) begin
						valid = 1'b1;
						b     = 10'(k - cfg.left_slot_start);
					end else if (in_win(k, cfg.right_slot_start, w)) begin
						valid = 1'b1;
						wd    = rw;
						b     = 10'(k - cfg.right_slot_start);
					end
				end else begin
					off = cfg.sync_polarity_variant ? 10'h000 :
						10'h001;
					if (in_win(k, off, w)) begin
						valid = 1'b1;
						b     = 10'(k - off);
					end else if (in_win(k, 10'(off + 10'(w)), w)) begin
						valid = 1'b1;
						wd    = rw;
						b     = 10'(k - off - 10'(w));
					end
				end
			end
			default: valid = 1'b0;
		endcase
		bit_val = wd[5'(10'd31 - b)];
		is_lsb  = valid && (b == 10'(w - 6'h1));
	end

	// ----------------------------------------------------------
	// framing state
	// ----------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			ph_ff   <= aasp_pkg::AASP_PH_IDLE;
			kcnt_ff <= 10'h000;
			pend_ff <= 1'b0;
		end else begin
			if (b_fall) begin
				ph_ff   <= ph_new;
				kcnt_ff <= (k == 10'h3FF) ? k : 10'(k + 10'h1);
			end
			pend_ff <= fs_edge ? !b_fall : (pend_ff && !b_fall);
		end
	end

	// words latched at the start of each left phase or frame
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			lword_ff        <= 32'h0000_0000;
			rword_ff        <= 32'h0000_0000;
			sample_take_out <= 1'b0;
		end else begin
			sample_take_out <= 1'b0;
			if (b_fall && !start) begin
				sample_take_out <= 1'b0;
			end else if (start && ph_new != aasp_pkg::AASP_PH_RIGHT) begin
				lword_ff        <= mk_word(left_sample_in, cfg.comp);
				rword_ff        <= mk_word(right_sample_in, cfg.comp);
				sample_take_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------
	// serial data pin
	// ----------------------------------------------------------
	// data and enable change on falls; early release on a rise
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			serial_data_out      <= 1'b0;
			serial_data_oe_n_out <= 1'b1;
			lsb_ff               <= 1'b0;
		end else if (b_fall) begin
			serial_data_out      <= valid && bit_val;
			serial_data_oe_n_out <= !valid && cfg.out_enable_select;
			lsb_ff               <= is_lsb;
		end else if (b_rise && lsb_ff && cfg.tri_early &&
				cfg.out_enable_select) begin
			serial_data_oe_n_out <= 1'b1;
			lsb_ff               <= 1'b0;
		end
	end

endmodule : aasp_serial_port

/* aasp_serial_port_bench.sv */
// self-checking bench of the audio serial output port
// assumes the checker bind and the host model are compiled first
`timescale 1ns/1ns
module aasp_serial_port_bench;
	logic        clk, rstn, rd, wr, host_run, last_sd;
	logic [9:0]  addr;
	logic [31:0] wdata, rdata;
	logic [23:0] lsmp, rsmp;
	logic        wait_r, bclk_o, bclk_oe_n, fs_o, fs_oe_n;
	logic        sd_o, sd_oe_n, take, host_bclk, host_fs;
	logic [63:0] arise, afall;
	logic [15:0] flen;
	int          failures, tests_run, cyc;
	// pin levels: released data shows the inverse of its last bit
	wire bclk_w = bclk_oe_n ? host_bclk : bclk_o;
	wire fs_w = fs_oe_n ? host_fs : fs_o;
	wire sd_w = sd_oe_n ? !last_sd : sd_o;

	aasp_serial_port i_aasp_serial_port (.core_clk_in(clk),
		.resetn_in(rstn), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
		.bclk_in(bclk_w), .bclk_out(bclk_o), .bclk_oe_n_out(bclk_oe_n),
		.frame_sync_in(fs_w), .frame_sync_out(fs_o),
		.frame_sync_oe_n_out(fs_oe_n), .serial_data_out(sd_o),
		.serial_data_oe_n_out(sd_oe_n), .left_sample_in(lsmp),
		.right_sample_in(rsmp), .sample_take_out(take));
	aasp_host_model i_aasp_host_model (.host_run_in(host_run),
		.bclk_w_in(bclk_w), .fs_w_in(fs_w), .data_w_in(sd_w),
		.host_bclk_out(host_bclk), .host_fs_out(host_fs),
		.after_rise_out(arise), .after_fall_out(afall),
		.frame_len_out(flen));

	always #25 clk = !clk;
	// last driven data bit, cycle count and hang limit
	always @(posedge clk) begin
		if (!sd_oe_n) last_sd <= sd_o;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [8:0] d, output logic [31:0] q);
		addr <= {idx, 2'b00};
		wdata <= {23'h0, d};
		rd <= !w;
		wr <= w;
		// waits for waitrequest low; only the bench hang limit ends a stuck wait
		do begin
			@(posedge clk);
		end while (wait_r !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [15:0] wd(input logic [63:0] a, input int s,
		input int n);
		logic [15:0] w;
		w = 16'h0000;
		for (int i = 0; i < n; i++) w = {w[14:0], a[s + i]};
		return w;
	endfunction : wd

	task automatic cfg(input logic [8:0] f, input logic [8:0] c,
		input logic [8:0] sl, input logic [8:0] sr);
		logic [31:0] q;
		bus(1'b1, aasp_pkg::IDX_SLOTL, sl, q);
		bus(1'b1, aasp_pkg::IDX_SLOTR, sr, q);
		bus(1'b1, aasp_pkg::IDX_SLOTC, c, q);
		bus(1'b1, aasp_pkg::IDX_CLK, 9'h002, q);
		bus(1'b1, aasp_pkg::IDX_FMT, f, q);
		repeat (1600) @(posedge clk);
	endtask : cfg

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_regs();
		logic [7:0]  ix [8] = '{8'h07, 8'h25, 8'h5B, 8'h5C, 8'h5D, 8'h10,
			8'h60, 8'h61};
		logic [15:0] ex [8] = '{16'h0020, 16'h0000, 16'h0000, 16'h0020,
			16'h0020, 16'h0000, 16'h0000, 16'h0004};
		logic [31:0] q;
		foreach (ix[i]) begin
			bus(1'b0, ix[i], 9'h000, q);
			chk(q[15:0], ex[i]);
		end
		bus(1'b1, 8'h25, 9'h007, q);
		bus(1'b1, 8'h10, 9'h1FF, q);
		bus(1'b0, 8'h25, 9'h000, q);
		chk(q[15:0], 16'h0007);
		bus(1'b0, 8'h10, 9'h000, q);
		chk(q[15:0], 16'h0000);
		bus(1'b1, 8'h25, 9'h000, q);
	endtask : t_regs

	task automatic t_lj();
		int n;
		cfg(9'h041, 9'h004, 9'h000, 9'h000);
		// one frame of 64 bit clocks holds exactly one sample take
		n = 0;
		repeat (512) @(posedge clk) n += take;
		chk(16'(n), 16'h0001);
		chk({15'h0, bclk_oe_n}, 16'h0000);
		chk(wd(arise, 0, 16), 16'hC35A);
		chk(wd(afall, 0, 16), 16'h3CA5);
		chk({15'h0, arise[16]}, 16'h0001);
	endtask : t_lj

	task automatic t_frame();
		logic [31:0] q;
		bus(1'b1, 8'h60, 9'h003, q);
		repeat (800) @(posedge clk);
		chk(flen, 16'h0020);
		bus(1'b1, 8'h60, 9'h001, q);
		repeat (2300) @(posedge clk);
		chk(flen, 16'h0080);
		bus(1'b1, 8'h60, 9'h000, q);
		repeat (4500) @(posedge clk);
		chk(flen, 16'h0100);
	endtask : t_frame

	task automatic t_rj_i2s();
		cfg(9'h040, 9'h000, 9'h000, 9'h000);
		chk(wd(arise, 16, 16), 16'hC35A);
		chk(wd(afall, 16, 16), 16'h3CA5);
		cfg(9'h042, 9'h000, 9'h000, 9'h000);
		chk(wd(afall, 1, 16), 16'hC35A);
		chk(wd(arise, 1, 16), 16'h3CA5);
	endtask : t_rj_i2s

	task automatic t_pcm();
		for (int f = 0; f < 2; f++) begin
			cfg(f ? 9'h053 : 9'h043, 9'h000, 9'h000, 9'h000);
			chk(wd(arise, 1 - f, 16), 16'hC35A);
			chk(wd(arise, 17 - f, 16), 16'h3CA5);
		end
		cfg(9'h043, 9'h100, 9'h003, 9'h028);
		chk(wd(arise, 3, 16), 16'hC35A);
		chk(wd(arise, 40, 16), 16'h3CA5);
	endtask : t_pcm

	task automatic t_comp();
		logic [1:0]  cd [4] = '{2'h0, 2'h2, 2'h3, 2'h2};
		logic [15:0] ex [4] = '{16'h00A5, 16'h00FF, 16'h00D5, 16'h00BE};
		logic [31:0] q;
		foreach (cd[i]) begin
			lsmp <= (i == 0) ? 24'hA5_0000 : (i == 3) ? 24'h10_0000 :
				24'h00_0000;
			bus(1'b1, 8'h25, {6'h00, cd[i], 1'b0}, q);
			cfg(9'h041, 9'h020, 9'h000, 9'h000);
			chk(wd(arise, 0, 8), ex[i]);
		end
		lsmp <= 24'hC3_5A00;
		bus(1'b1, 8'h25, 9'h000, q);
	endtask : t_comp

	task automatic t_slave();
		host_run <= 1'b1;
		cfg(9'h001, 9'h000, 9'h000, 9'h000);
		chk({15'h0, bclk_oe_n}, 16'h0001);
		chk(wd(arise, 0, 16), 16'hC35A);
		chk(wd(afall, 0, 16), 16'h3CA5);
		host_run <= 1'b0;
	endtask : t_slave

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		host_run = 1'b0;
		last_sd = 1'b0;
		addr = 10'h000;
		wdata = 32'h0;
		lsmp = 24'hC3_5A00;
		rsmp = 24'h3C_A500;
		failures = 0;
		tests_run = 0;
		cyc = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_lj();
		t_frame();
		t_rj_i2s();
		t_pcm();
		t_comp();
		t_slave();
		print_verdict();
	end
endmodule : aasp_serial_port_bench

/* aasp_sva.sv */
// port checker for the audio serial output port
// assumes a bind onto aasp_serial_port, one core clock domain
`timescale 1ns/1ns
module aasp_sva #(
	parameter int BCLK_HALF = 4
) (
	input wire logic        core_clk_in,
	input wire logic        resetn_in,
	input wire logic [9:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        bclk_out,
	input wire logic        bclk_oe_n_out,
	input wire logic        frame_sync_out,
	input wire logic        frame_sync_oe_n_out,
	input wire logic        serial_data_out,
	input wire logic        serial_data_oe_n_out,
	input wire logic        sample_take_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	// ----------------------------------------------------------
	// register bus
	// ----------------------------------------------------------
	chk_wait_answer: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("no answer one cycle after request");
	chk_wait_single: assert property (!avs_waitrequest_out |=>
		avs_waitrequest_out) else $error("waitrequest low too long");
	chk_unmapped_zero: assert property (avs_read_in && avs_waitrequest_out
		&& !(avs_address_in[9:2] inside {8'h07, 8'h25, 8'h5B, 8'h5C,
		8'h5D, 8'h60, 8'h61}) |=> avs_readdata_out == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property ($past(avs_read_in) &&
		!avs_waitrequest_out |-> avs_readdata_out[31:9] == 23'h0)
		else $error("read data above bit 8 not zero");
	chk_reset_out: assert property ($rose(resetn_in) |->
		avs_waitrequest_out && bclk_oe_n_out && serial_data_oe_n_out &&
		!sample_take_out) else $error("outputs wrong after reset");

	// ----------------------------------------------------------
	// serial link
	// ----------------------------------------------------------
	chk_master_pair: assert property (
		bclk_oe_n_out == frame_sync_oe_n_out)
		else $error("clock and sync not driven together");
	chk_data_hold: assert property (
		!bclk_oe_n_out && $past(!bclk_oe_n_out) && bclk_out &&
		$past(bclk_out) && !$past(avs_write_in) &&
		!$past(avs_write_in, 2) |-> $stable(serial_data_out))
		else $error("data moved while bit clock high");
	chk_sync_on_fall: assert property (
		!frame_sync_oe_n_out && $past(!frame_sync_oe_n_out) &&
		$changed(frame_sync_out) && !$past(avs_write_in) &&
		!$past(avs_write_in, 2) |-> $fell(bclk_out))
		else $error("sync moved off a bit clock fall");
	chk_take_pulse: assert property (sample_take_out |=>
		!sample_take_out) else $error("sample take longer than a cycle");
endmodule : aasp_sva

bind aasp_serial_port aasp_sva #(.BCLK_HALF(BCLK_HALF)) i_aasp_sva (
	.core_clk_in, .resetn_in, .avs_address_in, .avs_read_in,
	.avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .bclk_out,
	.bclk_oe_n_out, .frame_sync_out, .frame_sync_oe_n_out,
	.serial_data_out, .serial_data_oe_n_out, .sample_take_out);
